// ===== shared/acdp_pkg.sv
// Package for the converter clock divider and power control block.
// Assumes one 20 MHz clock and registers reached over the three-wire serial port.
`default_nettype none
package acdp_pkg;
   // Register offsets on the serial port.
   localparam logic [12:0] ADDR_POWER_MODE_CONTROL = 13'h0008;
   localparam logic [12:0] ADDR_CLOCK_DIVIDE_CONTROL = 13'h000b;
   localparam logic [12:0] ADDR_FULL_SCALE_RANGE_SELECT = 13'h0018;
   localparam logic [12:0] ADDR_DIVIDER_SYNC_CONTROL = 13'h003a;
   // Field positions.
   localparam int POS_SYNC_EVERY = 1;
   localparam int POS_SYNC_ONCE = 2;
   localparam int POS_SYNC_ARMED = 3;
   localparam int POS_STABILIZER_ENABLE = 4;
   localparam int POS_STABILIZER_LOCKED = 7;
   // Reset values.
   localparam logic [1:0] RST_POWER_MODE = 2'h0;
   localparam logic [4:0] RST_FULL_SCALE = 5'h00;
   localparam logic [2:0] RST_DIVIDE_CODE = 3'h0;
   localparam logic RST_STABILIZER_ENABLE = 1'b1;
   // Serial frame: sixteen instruction bits, then eight data bits.
   localparam logic [4:0] SPI_INSTR_BITS = 5'h10;
   localparam logic [4:0] SPI_FRAME_BITS = 5'h18;
   // Stabilizer relock wait, least figure, rounded up to clock cycles.
   localparam int CLK_HZ = 20000000;
   localparam int RELOCK_NS = 1500;
   localparam int RELOCK_CYCLES = (RELOCK_NS * (CLK_HZ / 1000000) + 999) / 1000;
   localparam logic [5:0] RELOCK_COUNT = 6'(RELOCK_CYCLES);

   // Power mode field codes; the fourth code runs as normal.
   typedef enum logic [1:0] {
      PM_NORMAL = 2'b00,
      PM_POWER_DOWN = 2'b01,
      PM_STANDBY = 2'b10,
      PM_SPARE = 2'b11
   } acdp_pmode_t;

   // Software settings held by the register file.
   typedef struct packed {
      logic [1:0] power_mode;
      logic [4:0] full_scale;
      logic sync_every;
      logic sync_once;
      logic [2:0] divide_code;
      logic duty_cycle_stabilizer;
   } acdp_cfg_t;

   // Power enables driven toward the analog side.
   typedef struct packed {
      logic power_down;
      logic standby;
      logic reference_on;
      logic ref_buffer_on;
      logic bias_on;
      logic clock_on;
      logic out_drive_en;
   } acdp_power_t;
endpackage : acdp_pkg
`default_nettype wire

// ===== logic/acdp_clock_power.sv
// Clock divider, duty cycle stabilizer control, sync alignment and power control.
// Assumes clk is the 20 MHz input clock; all pins arrive asynchronously.
`default_nettype none
module acdp_clock_power (
   input wire logic clk,
   input wire logic srst,
   input wire logic clk_en,
   input wire logic spi_sclk,
   input wire logic spi_csb_n,
   input wire logic spi_sdio_i,
   output logic spi_sdio_o,
   output logic spi_sdio_oe,
   input wire logic sync_pin,
   input wire logic power_down_pin,
   output logic sample_strobe,
   output logic div_clk,
   output logic stabilizer_locked,
   output logic [4:0] full_scale_code,
   output acdp_pkg::acdp_power_t power
);
   import acdp_pkg::*;

   // Two-stage synchronizers for every pin, plus a delayed copy for edge finding.
   logic [4:0] pin_s1_q, pin_s1_d, pin_s2_q, pin_s2_d, pin_s3_q, pin_s3_d;
   logic sclk_rise, sclk_fall, csb_n_s, sdio_s, sync_rise, pd_pin_s;

   always_comb begin
      pin_s1_d = {power_down_pin, sync_pin, spi_sdio_i, spi_csb_n, spi_sclk};
      pin_s2_d = pin_s1_q;
      pin_s3_d = pin_s2_q;
      sclk_rise = pin_s2_q[0] & ~pin_s3_q[0];
      sclk_fall = ~pin_s2_q[0] & pin_s3_q[0];
      csb_n_s = pin_s2_q[1];
      sdio_s = pin_s2_q[2];
      sync_rise = pin_s2_q[3] & ~pin_s3_q[3];
      pd_pin_s = pin_s2_q[4];
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         pin_s1_q <= 5'h02;
         pin_s2_q <= 5'h02;
         pin_s3_q <= 5'h02;
      end else if (clk_en) begin
         pin_s1_q <= pin_s1_d;
         pin_s2_q <= pin_s2_d;
         pin_s3_q <= pin_s3_d;
      end
   end

   // Serial port: instruction word, then one data byte shifted MSB first.
   logic [4:0] bit_cnt_q, bit_cnt_d;
   logic [15:0] instr_q, instr_d;
   logic [7:0] shift_q, shift_d;
   logic sdio_o_q, sdio_o_d, sdio_oe_q, sdio_oe_d;
   logic wr_stb;
   logic [12:0] wr_addr;
   logic [7:0] wr_data;

   // Register file and block state.
   acdp_cfg_t cfg_q, cfg_d;
   logic armed_q, armed_d;
   logic [2:0] div_cnt_q, div_cnt_d;
   logic [5:0] lock_cnt_q, lock_cnt_d;
   logic locked_q, locked_d;
   logic strobe_q, strobe_d, div_clk_q, div_clk_d;
   acdp_power_t power_q, power_d;
   logic sync_accept;

   // Read mux shared by the serial port; unmapped addresses read as zero.
   function automatic logic [7:0] read_reg(input logic [12:0] addr, input acdp_cfg_t c,
                                           input logic armed, input logic locked);
      logic [7:0] v;
      v = 8'h00;
      unique case (addr)
         ADDR_POWER_MODE_CONTROL: v[1:0] = c.power_mode;
         ADDR_FULL_SCALE_RANGE_SELECT: v[4:0] = c.full_scale;
         ADDR_CLOCK_DIVIDE_CONTROL: begin
            v[2:0] = c.divide_code;
            v[POS_STABILIZER_ENABLE] = c.duty_cycle_stabilizer;
            v[POS_STABILIZER_LOCKED] = locked;
         end
         ADDR_DIVIDER_SYNC_CONTROL: begin
            v[POS_SYNC_EVERY] = c.sync_every;
            v[POS_SYNC_ONCE] = c.sync_once;
            v[POS_SYNC_ARMED] = armed;
         end
         default: v = 8'h00;
      endcase
      return v;
   endfunction : read_reg

   // Serial slave next state; a raised chip select abandons any partial frame.
   always_comb begin
      bit_cnt_d = bit_cnt_q;
      instr_d = instr_q;
      shift_d = shift_q;
      sdio_o_d = sdio_o_q;
      sdio_oe_d = sdio_oe_q;
      wr_stb = 1'b0;
      wr_addr = instr_q[12:0];
      wr_data = {shift_q[6:0], sdio_s};
      if (csb_n_s) begin
         bit_cnt_d = 5'h00;
         sdio_oe_d = 1'b0;
      end else if (sclk_rise && bit_cnt_q < SPI_FRAME_BITS) begin
         bit_cnt_d = bit_cnt_q + 5'h01;
         if (bit_cnt_q < SPI_INSTR_BITS) begin
            instr_d = {instr_q[14:0], sdio_s};
         end else if (!instr_q[15]) begin // A read keeps its loaded byte intact.
            shift_d = {shift_q[6:0], sdio_s};
         end
         if (bit_cnt_q == SPI_INSTR_BITS - 5'h01 && instr_q[14]) begin
            // Read: load the byte now and start driving on the next falling edge.
            shift_d = read_reg({instr_q[11:0], sdio_s}, cfg_q, armed_q, lock_cnt_q == 6'h00);
         end
         if (bit_cnt_q == SPI_FRAME_BITS - 5'h01 && !instr_q[15]) begin
            wr_stb = 1'b1;
         end
      end else if (sclk_fall && instr_q[15] && bit_cnt_q >= SPI_INSTR_BITS
                   && bit_cnt_q < SPI_FRAME_BITS) begin
         sdio_oe_d = 1'b1;
         sdio_o_d = shift_q[7];
         shift_d = {shift_q[6:0], 1'b0};
      end else if (bit_cnt_q == SPI_FRAME_BITS && sclk_fall) begin
         sdio_oe_d = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         bit_cnt_q <= 5'h00;
         instr_q <= 16'h0000;
         shift_q <= 8'h00;
         sdio_o_q <= 1'b0;
         sdio_oe_q <= 1'b0;
      end else if (clk_en) begin
         bit_cnt_q <= bit_cnt_d;
         instr_q <= instr_d;
         shift_q <= shift_d;
         sdio_o_q <= sdio_o_d;
         sdio_oe_q <= sdio_oe_d;
      end
   end

   // Register writes, sync arming and stabilizer relock timing.
   always_comb begin
      cfg_d = cfg_q;
      armed_d = armed_q;
      lock_cnt_d = lock_cnt_q;
      // A sync is taken only with sync_every set; with sync_once also set it is taken only while armed.
      sync_accept = sync_rise && cfg_q.sync_every && (!cfg_q.sync_once || armed_q);
      if (sync_accept) begin
         armed_d = 1'b0;
      end
      if (lock_cnt_q != 6'h00) begin
         lock_cnt_d = lock_cnt_q - 6'h01;
      end
      if (wr_stb) begin
         unique case (wr_addr)
            ADDR_POWER_MODE_CONTROL: cfg_d.power_mode = wr_data[1:0];
            ADDR_FULL_SCALE_RANGE_SELECT: cfg_d.full_scale = wr_data[4:0];
            ADDR_CLOCK_DIVIDE_CONTROL: begin
               cfg_d.divide_code = wr_data[2:0];
               cfg_d.duty_cycle_stabilizer = wr_data[POS_STABILIZER_ENABLE];
               // A new ratio changes the sample rate, so the loop must relock.
               if (wr_data[2:0] != cfg_q.divide_code) begin
                  lock_cnt_d = RELOCK_COUNT;
               end
            end
            ADDR_DIVIDER_SYNC_CONTROL: begin
               cfg_d.sync_every = wr_data[POS_SYNC_EVERY];
               cfg_d.sync_once = wr_data[POS_SYNC_ONCE];
               armed_d = 1'b1;
            end
            default: cfg_d = cfg_q;
         endcase
      end
      // Coming back from power-down the clock restarts, so relock as well.
      if (power_q.power_down) begin
         lock_cnt_d = RELOCK_COUNT;
      end
      locked_d = (lock_cnt_d == 6'h00);
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         cfg_q <= '{power_mode: RST_POWER_MODE, full_scale: RST_FULL_SCALE,
                    sync_every: 1'b0, sync_once: 1'b0, divide_code: RST_DIVIDE_CODE,
                    duty_cycle_stabilizer: RST_STABILIZER_ENABLE};
         armed_q <= 1'b0;
         lock_cnt_q <= RELOCK_COUNT;
         locked_q <= 1'b0;
      end else if (clk_en) begin
         cfg_q <= cfg_d;
         armed_q <= armed_d;
         lock_cnt_q <= lock_cnt_d;
         locked_q <= locked_d;
      end
   end

   // Divider. The sampling edge is the count wrap; the stabilizer shapes the
   // low edge for about half duty. At ratio one the clock itself is the sample
   // clock and no flop can shape it; div_clk then stays low, or stays high while the stabilizer is on and locked.
   always_comb begin
      logic [2:0] half;
      half = 3'(({1'b0, cfg_q.divide_code} + 4'h2) >> 1); // Odd ratios round the high time up.
      div_cnt_d = div_cnt_q;
      strobe_d = 1'b0;
      div_clk_d = 1'b0;
      if (!power_q.clock_on) begin
         div_cnt_d = 3'h0;
      end else if (sync_accept) begin
         div_cnt_d = 3'h0;
      end else begin
         div_cnt_d = (div_cnt_q >= cfg_q.divide_code) ? 3'h0 : div_cnt_q + 3'h1;
         strobe_d = (div_cnt_d == 3'h0);
         // The loop only runs once locked; the clock rate here is treated as
         // above the range where it would fail to settle.
         if (cfg_q.duty_cycle_stabilizer && lock_cnt_q == 6'h00) begin
            div_clk_d = div_cnt_d < half;
         end else begin
            div_clk_d = (div_cnt_d == 3'h0) && (cfg_q.divide_code != 3'h0);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         div_cnt_q <= 3'h0;
         strobe_q <= 1'b0;
         div_clk_q <= 1'b0;
      end else if (clk_en) begin
         div_cnt_q <= div_cnt_d;
         strobe_q <= strobe_d;
         div_clk_q <= div_clk_d;
      end
   end

   // Power state decode; pin and field are ORed for power-down.
   always_comb begin
      logic field_pd, field_sb;
      field_pd = (cfg_q.power_mode == PM_POWER_DOWN);
      field_sb = (cfg_q.power_mode == PM_STANDBY);
      power_d.power_down = field_pd || pd_pin_s;
      power_d.standby = field_sb && !pd_pin_s;
      power_d.reference_on = !power_d.power_down;
      power_d.ref_buffer_on = !power_d.power_down && !field_sb;
      power_d.bias_on = !power_d.power_down && !field_sb;
      power_d.clock_on = !power_d.power_down;
      power_d.out_drive_en = !power_d.power_down;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         power_q <= '{power_down: 1'b0, standby: 1'b0, reference_on: 1'b1,
                      ref_buffer_on: 1'b1, bias_on: 1'b1, clock_on: 1'b1,
                      out_drive_en: 1'b1};
      end else if (clk_en) begin
         power_q <= power_d;
      end
   end

   // Outputs come straight from flops.
   assign spi_sdio_o = sdio_o_q;
   assign spi_sdio_oe = sdio_oe_q;
   assign sample_strobe = strobe_q;
   assign div_clk = div_clk_q;
   assign stabilizer_locked = locked_q;
   assign full_scale_code = cfg_q.full_scale;
   assign power = power_q;
endmodule : acdp_clock_power
`default_nettype wire

// ===== tb/acdp_clock_power_assertions.sv
// Checker for the clock and power block, bound to the ports of its top module.
// Assumes clk_en drops only briefly, with the pins quiet meanwhile.
`default_nettype none
module acdp_clock_power_assertions (
   input wire logic clk,
   input wire logic srst,
   input wire logic power_down_pin,
   input wire logic sample_strobe,
   input wire logic div_clk,
   input wire logic stabilizer_locked,
   input wire acdp_pkg::acdp_power_t power
);
   import acdp_pkg::*;
   logic [4:0] gap_q, gap_d;
   logic [5:0] ulk_q, ulk_d;
   // Cycles since the last strobe, and since lock was lost; the lock count saturates.
   always_comb begin
      gap_d = (srst || sample_strobe || !power.clock_on) ? 5'h00 : gap_q + 5'h01;
      ulk_d = srst ? 6'h3f : (stabilizer_locked ? 6'h00 : ulk_q + 6'(ulk_q != 6'h3f));
   end
   // Registers only.
   always_ff @(posedge clk) begin
      gap_q <= gap_d;
      ulk_q <= ulk_d;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   AST_PIN_PD: assert property (power_down_pin [*5] |-> power.power_down)
      else $error("pin high but not powered down");
   AST_PD_OFF: assert property (power.power_down |-> !(power.reference_on |
      power.ref_buffer_on | power.bias_on | power.clock_on | power.out_drive_en))
      else $error("power-down left a supply or driver on");
   AST_STANDBY: assert property (power.standby |-> power.reference_on &&
      power.out_drive_en && !power.power_down)
      else $error("standby lost reference or outputs");
   AST_NORMAL: assert property (!power.power_down && !power.standby |->
      power.reference_on && power.bias_on && power.clock_on && power.out_drive_en)
      else $error("normal mode with a supply off");
   AST_STROBE_GAP: assert property (gap_q < 5'h10)
      else $error("strobe gap beyond any ratio");
   AST_RAW: assert property ((!stabilizer_locked) [*3] ##0 div_clk |=>
      !div_clk || stabilizer_locked)
      else $error("unlocked clock high for two cycles");
   AST_PD_RELOCK: assert property (power.power_down [*2] |-> !stabilizer_locked)
      else $error("locked while powered down");
   AST_LOCK_WAIT: assert property ($rose(stabilizer_locked) |-> ulk_q >= 6'h1d)
      else $error("relocked too early");
   cover property ($rose(power.power_down));
   cover property (power.standby);
   cover property ($rose(stabilizer_locked));
endmodule : acdp_clock_power_assertions
bind acdp_clock_power acdp_clock_power_assertions chk (.clk(clk), .srst(srst),
   .power_down_pin(power_down_pin), .sample_strobe(sample_strobe), .div_clk(div_clk),
   .stabilizer_locked(stabilizer_locked), .power(power));
`default_nettype wire

// ===== tb/acdp_sync_model.sv
// Model of the far-side alignment driver.
// Assumes the bench calls pulse at a falling clock edge.
`default_nettype none
module acdp_sync_model (
   input wire logic clk,
   output var logic sync_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   initial sync_pin = 1'b0;
   // A pulse of four cycles is long enough for any synchronizer to see.
   task automatic pulse();
      sync_pin <= 1'b1;
      repeat (4) @(negedge clk);
      sync_pin <= 1'b0;
   endtask : pulse
endmodule : acdp_sync_model
`default_nettype wire

// ===== tb/acdp_clock_power_tb.sv
// Self-checking bench for the clock divider and power control block.
// Assumes the serial port and sync model are the only masters of the pins.
`default_nettype none
module acdp_clock_power_tb;
   import acdp_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, srst = 1, sclk = 0, csb_n = 1, sdio_tb = 0, pd_pin = 0, en = 1;
   logic sdio_o, sdio_oe, sync_pin, strobe, div_clk, locked;
   logic [4:0] fs;
   acdp_power_t pwr;
   int fails = 0, compares = 0;
   wire logic sdio = sdio_oe ? sdio_o : sdio_tb;
   // Clock at 20 MHz.
   always #25 clk = ~clk;
   acdp_clock_power dut (.clk(clk), .srst(srst), .clk_en(en), .spi_sclk(sclk),
      .spi_csb_n(csb_n), .spi_sdio_i(sdio), .spi_sdio_o(sdio_o), .spi_sdio_oe(sdio_oe),
      .sync_pin(sync_pin), .power_down_pin(pd_pin), .sample_strobe(strobe),
      .div_clk(div_clk), .stabilizer_locked(locked), .full_scale_code(fs), .power(pwr));
   acdp_sync_model partner (.clk(clk), .sync_pin(sync_pin));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic wrap_up();
      if (fails == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : wrap_up
   // High cycles of div_clk per period: half the ratio rounded up when stabilized, else one.
   function automatic logic [7:0] exp_hi(input int r, input int s);
      return 8'(s != 0 ? (r + 1) / 2 : 1);
   endfunction : exp_hi
   // Power-down and standby flags for a mode code and the pin level.
   function automatic logic [7:0] exp_pwr(input logic [1:0] mode, input logic pin);
      return {6'h00, mode == PM_POWER_DOWN || pin, mode == PM_STANDBY && !pin};
   endfunction : exp_pwr
   // One frame; each sclk level lasts four clocks, safely above the three-clock floor.
   task automatic spi(input logic rd, input logic [12:0] a, input logic [7:0] wd,
         output logic [7:0] rdat);
      logic [23:0] frame;
      frame = {rd, 2'b00, a, wd};
      @(negedge clk);
      csb_n = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         sdio_tb = frame[i];
         repeat (4) @(negedge clk);
         sclk = 1'b1;
         if (i < 8) rdat[i] = sdio;
         repeat (4) @(negedge clk);
         sclk = 1'b0;
      end
      repeat (4) @(negedge clk);
      csb_n = 1'b1;
      repeat (6) @(negedge clk);
   endtask : spi
   task automatic wr(input logic [12:0] a, input logic [7:0] d);
      logic [7:0] x;
      spi(1'b0, a, d, x);
   endtask : wr
   // Cycles until the next strobe, bounded so a dead divider cannot hang the run.
   task automatic till_strobe(output int n);
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (strobe !== 1'b1 && n < 40);
   endtask : till_strobe
   // High cycles of div_clk over one divided period.
   task automatic duty(input int r, output int hi);
      int n;
      till_strobe(n);
      hi = 0;
      repeat (r) begin
         @(posedge clk);
         #1;
         hi += (div_clk === 1'b1);
      end
   endtask : duty
   // Launch a sync ph cycles after a strobe and time the next strobe.
   task automatic sync_at(input int ph, output int d);
      till_strobe(d);
      repeat (ph + 1) @(negedge clk);
      fork
         partner.pulse();
      join_none
      till_strobe(d);
      repeat (8) @(negedge clk);
   endtask : sync_at
   // Watchdog well beyond the expected run of about 10,000 cycles.
   initial begin
      #3000000;
      fails++;
      wrap_up();
   end
   // Main sequence.
   initial begin
      logic [7:0] x;
      logic [4:0] v;
      int n, d1, hi;
      void'($urandom(32'h7a99));
      repeat (6) @(negedge clk);
      srst = 1'b0;
      check({3'h0, fs}, {3'h0, RST_FULL_SCALE});
      spi(1'b1, ADDR_POWER_MODE_CONTROL, 8'h00, x);
      check({6'h00, x[1:0]}, {6'h00, RST_POWER_MODE});
      spi(1'b1, 13'h0001, 8'h00, x);
      check(x, 8'h00);
      for (int j = 0; j < 6; j++) begin
         v = (j < 2) ? 5'(j * 31) : 5'($urandom);
         wr(ADDR_FULL_SCALE_RANGE_SELECT, {3'h0, v});
         check({3'h0, fs}, {3'h0, v});
         spi(1'b1, ADDR_FULL_SCALE_RANGE_SELECT, 8'($urandom), x);
         check(x, {3'h0, v});
      end
      for (int r = 1; r <= 8; r++) begin
         for (int s = 1; s >= 0; s--) begin
            if (s == 0 && r != 1 && r != 2 && r != 4) continue;
            wr(ADDR_CLOCK_DIVIDE_CONTROL, {3'h0, 1'(s), 1'b0, 3'(r - 1)});
            duty(r, hi);
            if (r > 1) check(8'(hi), 8'h01);
            repeat (40) @(negedge clk);
            check({7'h00, locked}, 8'h01);
            till_strobe(n);
            till_strobe(n);
            check(8'(n), 8'(r));
            duty(r, hi);
            if (r > 1) check(8'(hi), exp_hi(r, s));
         end
      end
      wr(ADDR_CLOCK_DIVIDE_CONTROL, 8'h14);
      repeat (40) @(negedge clk);
      spi(1'b1, ADDR_CLOCK_DIVIDE_CONTROL, 8'h00, x);
      check(x, 8'h94);
      // A frozen block holds its strobe high and resumes the count where it stopped.
      till_strobe(n);
      @(negedge clk);
      en = 1'b0;
      repeat (8) @(negedge clk);
      check({7'h00, strobe}, 8'h01);
      en = 1'b1;
      till_strobe(n);
      check(8'(n), 8'h05);
      wr(ADDR_DIVIDER_SYNC_CONTROL, 8'h02);
      sync_at(0, d1);
      check(8'(d1 >= 7 && d1 <= 10), 8'h01);
      sync_at(1, n);
      check(8'(n), 8'(d1));
      wr(ADDR_DIVIDER_SYNC_CONTROL, 8'h06);
      spi(1'b1, ADDR_DIVIDER_SYNC_CONTROL, 8'h00, x);
      check(x, 8'h0e);
      sync_at(0, n);
      check(8'(n), 8'(d1));
      spi(1'b1, ADDR_DIVIDER_SYNC_CONTROL, 8'h00, x);
      check(x, 8'h06);
      sync_at(1, n);
      check(8'(n), 8'h04);
      wr(ADDR_DIVIDER_SYNC_CONTROL, 8'h00);
      sync_at(1, n);
      check(8'(n), 8'h04);
      for (int k = 0; k < 8; k++) begin
         pd_pin = k[2];
         wr(ADDR_POWER_MODE_CONTROL, 8'(k % 4));
         check({6'h00, pwr.power_down, pwr.standby}, exp_pwr(k[1:0], k[2]));
      end
      pd_pin = 1'b0;
      wr(ADDR_POWER_MODE_CONTROL, 8'h00);
      check({7'h00, pwr.out_drive_en}, 8'h01);
      wrap_up();
   end
endmodule : acdp_clock_power_tb
`default_nettype wire
